// ==== itm_pkg.sv ====
// constants shared by the interval timer and its count-clock generator
package itm_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR = 32'hfffff690;
    localparam logic [31:0] CMP_ADDR  = 32'hfffff694;
    localparam logic [31:0] STAT_ADDR = 32'hfffff698;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_RUN_BIT     = 7;
    localparam int          CKS_W            = 3;
    localparam logic [7:0]  CTRL_RST         = 8'h00;
    localparam logic [15:0] CMP_RST          = 16'h0000;
    localparam logic [15:0] CNT_IDLE         = 16'hffff;
    localparam int          STAT_STARTED_BIT = 0;
    localparam int          STAT_MATCH_BIT   = 1;

    // ------------------------------------------------------------
    // count clock select codes
    // ------------------------------------------------------------
    localparam logic [2:0] CKS_MAIN   = 3'h0;
    localparam logic [2:0] CKS_DIV2   = 3'h1;
    localparam logic [2:0] CKS_DIV4   = 3'h2;
    localparam logic [2:0] CKS_DIV64  = 3'h3;
    localparam logic [2:0] CKS_DIV512 = 3'h4;
    localparam logic [2:0] CKS_WATCH  = 3'h5;
    localparam logic [2:0] CKS_OSC8   = 3'h6;
    localparam logic [2:0] CKS_SUB    = 3'h7;

    // ------------------------------------------------------------
    // prescaler terminal masks and oscillator divide
    // ------------------------------------------------------------
    localparam int         PRE_W       = 9;
    localparam logic [8:0] DIV2_MASK   = 9'h001;
    localparam logic [8:0] DIV4_MASK   = 9'h003;
    localparam logic [8:0] DIV64_MASK  = 9'h03f;
    localparam logic [8:0] DIV512_MASK = 9'h1ff;
    localparam logic [2:0] OSC_LAST    = 3'h7;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== itm_tick_if.sv ====
// run/select/tick bundle between the timer core and its count-clock generator
`timescale 1ns/1ps
`default_nettype none
interface itm_tick_if;
    logic       run;
    logic [2:0] sel;
    logic       tick;
    modport timer (output run, output sel, input tick);
    modport gen   (input run, input sel, output tick);
endinterface
`default_nettype wire

// ==== itm_tick_gen.sv ====
// count-clock enable generator: prescaler, pin synchronisers and source select
`timescale 1ns/1ps
`default_nettype none
module itm_tick_gen #(
    parameter int PRE_W = itm_pkg::PRE_W
) (
    input  wire logic   clk,
    input  wire logic   rstN,
    input  wire logic   watchTickIrq,
    input  wire logic   internalOscClock,
    input  wire logic   subclock,
    itm_tick_if.gen     tk
);
    // refused at elaboration: the divide-by-512 tap needs nine bits
    if (PRE_W < 9) begin : g_preCheck
        $error("prescaler must reach divide by 512");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0]       syncA_ff;
    logic [2:0]       syncB_ff;
    logic [2:0]       prev_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [2:0]       oscDiv_ff;
    logic             tick_ff;
    logic [PRE_W-1:0] nxt_pre;
    logic [2:0]       nxt_oscDiv;
    logic             nxt_tick;
    logic [2:0]       rise;
    logic [8:0]       preLow;

    // edges come from the second stage only; the first stage feeds nothing else
    assign rise   = syncB_ff & ~prev_ff;
    assign preLow = pre_ff[8:0];
    assign tk.tick = tick_ff;

    // prescaler and oscillator divider both restart while stopped
    always_comb begin
        nxt_pre    = '0;
        nxt_oscDiv = 3'h0;
        nxt_tick   = 1'b0;
        if (tk.run) begin
            nxt_pre    = pre_ff + 1'b1;
            nxt_oscDiv = rise[1] ? oscDiv_ff + 3'h1 : oscDiv_ff;
            case (tk.sel)
                itm_pkg::CKS_MAIN:   nxt_tick = 1'b1;
                itm_pkg::CKS_DIV2:   nxt_tick = (preLow & itm_pkg::DIV2_MASK) == itm_pkg::DIV2_MASK;
                itm_pkg::CKS_DIV4:   nxt_tick = (preLow & itm_pkg::DIV4_MASK) == itm_pkg::DIV4_MASK;
                itm_pkg::CKS_DIV64:  nxt_tick = (preLow & itm_pkg::DIV64_MASK) == itm_pkg::DIV64_MASK;
                itm_pkg::CKS_DIV512: nxt_tick = preLow == itm_pkg::DIV512_MASK;
                itm_pkg::CKS_WATCH:  nxt_tick = rise[0];
                itm_pkg::CKS_OSC8:   nxt_tick = rise[1] && (oscDiv_ff == itm_pkg::OSC_LAST);
                itm_pkg::CKS_SUB:    nxt_tick = rise[2];
                default:             nxt_tick = 1'b0;
            endcase
        end
    end

    // registers; tick is a one-cycle enable, never a derived clock
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            syncA_ff  <= 3'h0;
            syncB_ff  <= 3'h0;
            prev_ff   <= 3'h0;
            pre_ff    <= '0;
            oscDiv_ff <= 3'h0;
            tick_ff   <= 1'b0;
        end else begin
            syncA_ff  <= {subclock, internalOscClock, watchTickIrq};
            syncB_ff  <= syncA_ff;
            prev_ff   <= syncB_ff;
            pre_ff    <= nxt_pre;
            oscDiv_ff <= nxt_oscDiv;
            tick_ff   <= nxt_tick;
        end
    end
endmodule
`default_nettype wire

// ==== itm_interval_timer.sv ====
// 16-bit clear-and-start interval timer with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module itm_interval_timer (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        watchTickIrq,
    input  wire logic        internalOscClock,
    input  wire logic        subclock,
    output var  logic        compareMatchIrq
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstA_ff;
    logic rstN_ff;

    // assert at once, release after two edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstA_ff <= 1'b0;
            rstN_ff <= 1'b0;
        end else begin
            rstA_ff <= 1'b1;
            rstN_ff <= rstA_ff;
        end
    end

    // ------------------------------------------------------------
    // count clock generator
    // ------------------------------------------------------------
    itm_tick_if tkBus ();

    itm_tick_gen #(
        .PRE_W (itm_pkg::PRE_W)
    ) u_tick (
        .clk              (core_clk),
        .rstN             (rstN_ff),
        .watchTickIrq     (watchTickIrq),
        .internalOscClock (internalOscClock),
        .subclock         (subclock),
        .tk               (tkBus.gen)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                     awReady_ff;
    logic                     wReady_ff;
    logic                     awHeld_ff;
    logic                     wHeld_ff;
    logic [31:0]              awAddr_ff;
    logic [31:0]              wData_ff;
    logic [3:0]               wStrb_ff;
    logic                     bValid_ff;
    logic [1:0]               bResp_ff;
    logic                     arReady_ff;
    logic                     rValid_ff;
    logic [31:0]              rData_ff;
    logic [1:0]               rResp_ff;
    logic                     run_ff;
    logic [itm_pkg::CKS_W-1:0] cks_ff;
    logic [15:0]              cmp_ff;
    logic [15:0]              cnt_ff;
    logic                     irq_ff;
    logic                     started_ff;
    logic                     matchSeen_ff;

    logic                     nxt_awReady;
    logic                     nxt_wReady;
    logic                     nxt_awHeld;
    logic                     nxt_wHeld;
    logic [31:0]              nxt_awAddr;
    logic [31:0]              nxt_wData;
    logic [3:0]               nxt_wStrb;
    logic                     nxt_bValid;
    logic [1:0]               nxt_bResp;
    logic                     nxt_arReady;
    logic                     nxt_rValid;
    logic [31:0]              nxt_rData;
    logic [1:0]               nxt_rResp;
    logic                     nxt_run;
    logic [itm_pkg::CKS_W-1:0] nxt_cks;
    logic [15:0]              nxt_cmp;
    logic [15:0]              nxt_cnt;
    logic                     nxt_irq;
    logic                     nxt_started;
    logic                     nxt_matchSeen;

    logic                     doWrite;
    logic                     hitCtrl;
    logic                     hitCmp;
    logic                     hitStat;
    logic                     match;
    logic [7:0]               ctrlView;

    assign tkBus.run = run_ff;
    assign tkBus.sel = cks_ff;

    // bits 6:3 are not stored and read back as zero
    assign ctrlView = {run_ff, 4'h0, cks_ff};

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    // address and data are caught in either order; the write lands once both are held
    assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
    assign hitCtrl = awAddr_ff == itm_pkg::CTRL_ADDR;
    assign hitCmp  = awAddr_ff == itm_pkg::CMP_ADDR;
    assign hitStat = awAddr_ff == itm_pkg::STAT_ADDR;

    always_comb begin
        nxt_awHeld = awHeld_ff;
        nxt_wHeld  = wHeld_ff;
        nxt_awAddr = awAddr_ff;
        nxt_wData  = wData_ff;
        nxt_wStrb  = wStrb_ff;
        nxt_bValid = bValid_ff;
        nxt_bResp  = bResp_ff;
        if (s_axi_awvalid && awReady_ff) begin
            nxt_awHeld = 1'b1;
            nxt_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_ff) begin
            nxt_wHeld = 1'b1;
            nxt_wData = s_axi_wdata;
            nxt_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            nxt_awHeld = 1'b0;
            nxt_wHeld  = 1'b0;
            nxt_bValid = 1'b1;
            nxt_bResp  = (hitCtrl || hitCmp || hitStat) ? itm_pkg::RESP_OKAY
                                                         : itm_pkg::RESP_SLVERR;
        end else if (bValid_ff && s_axi_bready) begin
            nxt_bValid = 1'b0;
        end
        // ready only while the slot is empty and no response is pending
        nxt_awReady = !nxt_awHeld && !nxt_bValid;
        nxt_wReady  = !nxt_wHeld && !nxt_bValid;
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // the count itself has no address, so it cannot be read
    // ready returns once no read data is pending, also out of reset
    always_comb begin
        nxt_arReady = arReady_ff || !rValid_ff;
        nxt_rValid  = rValid_ff;
        nxt_rData   = rData_ff;
        nxt_rResp   = rResp_ff;
        if (s_axi_arvalid && arReady_ff) begin
            nxt_arReady = 1'b0;
            nxt_rValid  = 1'b1;
            nxt_rResp   = itm_pkg::RESP_OKAY;
            nxt_rData   = 32'h0000_0000;
            if (s_axi_araddr == itm_pkg::CTRL_ADDR) begin
                nxt_rData = {24'h00_0000, ctrlView};
            end else if (s_axi_araddr == itm_pkg::CMP_ADDR) begin
                nxt_rData = {16'h0000, cmp_ff};
            end else if (s_axi_araddr == itm_pkg::STAT_ADDR) begin
                nxt_rData = {30'h0, matchSeen_ff, started_ff};
            end else begin
                nxt_rResp = itm_pkg::RESP_SLVERR;
            end
        end else if (rValid_ff && s_axi_rready) begin
            nxt_rValid  = 1'b0;
            nxt_arReady = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers and counter
    // ------------------------------------------------------------
    // compare is taken only as a full low halfword; run-time rewrites are
    // software's to avoid, the hardware simply takes them
    assign match = tkBus.tick && (cnt_ff == cmp_ff);

    always_comb begin
        nxt_run       = run_ff;
        nxt_cks       = cks_ff;
        nxt_cmp       = cmp_ff;
        nxt_matchSeen = matchSeen_ff;
        if (doWrite && hitCtrl && wStrb_ff[0]) begin
            nxt_run = wData_ff[itm_pkg::CTRL_RUN_BIT];
            nxt_cks = wData_ff[itm_pkg::CKS_W-1:0];
        end
        if (doWrite && hitCmp && (wStrb_ff[1:0] == 2'h3)) begin
            nxt_cmp = wData_ff[15:0];
        end
        if (doWrite && hitStat && wStrb_ff[0] && wData_ff[itm_pkg::STAT_MATCH_BIT]) begin
            nxt_matchSeen = 1'b0;
        end
        // a match in the clearing cycle still sets the flag
        if (run_ff && match) begin
            nxt_matchSeen = 1'b1;
        end
        // stopped: counter parked at all-ones, no enable reaches it
        nxt_cnt     = itm_pkg::CNT_IDLE;
        nxt_started = 1'b0;
        nxt_irq     = 1'b0;
        if (run_ff) begin
            nxt_cnt     = cnt_ff;
            nxt_started = started_ff;
            if (tkBus.tick) begin
                nxt_started = 1'b1;
                if (match) begin
                    nxt_cnt = 16'h0000;
                    nxt_irq = 1'b1;
                end else begin
                    // all-ones wraps to zero on the first tick
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
        end
    end

    // all state on the released reset
    always_ff @(posedge core_clk or negedge rstN_ff) begin
        if (!rstN_ff) begin
            awReady_ff   <= 1'b0;
            wReady_ff    <= 1'b0;
            awHeld_ff    <= 1'b0;
            wHeld_ff     <= 1'b0;
            awAddr_ff    <= 32'h0000_0000;
            wData_ff     <= 32'h0000_0000;
            wStrb_ff     <= 4'h0;
            bValid_ff    <= 1'b0;
            bResp_ff     <= itm_pkg::RESP_OKAY;
            arReady_ff   <= 1'b0;
            rValid_ff    <= 1'b0;
            rData_ff     <= 32'h0000_0000;
            rResp_ff     <= itm_pkg::RESP_OKAY;
            run_ff       <= itm_pkg::CTRL_RST[itm_pkg::CTRL_RUN_BIT];
            cks_ff       <= itm_pkg::CTRL_RST[itm_pkg::CKS_W-1:0];
            cmp_ff       <= itm_pkg::CMP_RST;
            cnt_ff       <= itm_pkg::CNT_IDLE;
            irq_ff       <= 1'b0;
            started_ff   <= 1'b0;
            matchSeen_ff <= 1'b0;
        end else begin
            awReady_ff   <= nxt_awReady;
            wReady_ff    <= nxt_wReady;
            awHeld_ff    <= nxt_awHeld;
            wHeld_ff     <= nxt_wHeld;
            awAddr_ff    <= nxt_awAddr;
            wData_ff     <= nxt_wData;
            wStrb_ff     <= nxt_wStrb;
            bValid_ff    <= nxt_bValid;
            bResp_ff     <= nxt_bResp;
            arReady_ff   <= nxt_arReady;
            rValid_ff    <= nxt_rValid;
            rData_ff     <= nxt_rData;
            rResp_ff     <= nxt_rResp;
            run_ff       <= nxt_run;
            cks_ff       <= nxt_cks;
            cmp_ff       <= nxt_cmp;
            cnt_ff       <= nxt_cnt;
            irq_ff       <= nxt_irq;
            started_ff   <= nxt_started;
            matchSeen_ff <= nxt_matchSeen;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready   = awReady_ff;
    assign s_axi_wready    = wReady_ff;
    assign s_axi_bvalid    = bValid_ff;
    assign s_axi_bresp     = bResp_ff;
    assign s_axi_arready   = arReady_ff;
    assign s_axi_rvalid    = rValid_ff;
    assign s_axi_rdata     = rData_ff;
    assign s_axi_rresp     = rResp_ff;
    assign compareMatchIrq = irq_ff;
endmodule
`default_nettype wire

// ==== itm_interval_timer_properties.sv ====
// checker of register bus handshakes and run gating of the interval timer
`timescale 1ns/1ps
`default_nettype none
module itm_interval_timer_properties (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        watchTickIrq,
    input wire logic        internalOscClock,
    input wire logic        subclock,
    input wire logic        compareMatchIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic wrTake;
    logic runSeen_ff;
    logic nxt_runSeen;
    // ----------------------------------------------------------------
    // shadow of the run bit
    // ----------------------------------------------------------------
    // only sees writes whose address and data meet on one edge
    always_comb begin
        wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
        nxt_runSeen = runSeen_ff;
        if (wrTake && s_axi_awaddr == itm_pkg::CTRL_ADDR && s_axi_wstrb[0]) begin
            nxt_runSeen = s_axi_wdata[7];
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            runSeen_ff <= 1'b0;
        end else begin
            runSeen_ff <= nxt_runSeen;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    // the write lands one edge after it is taken, the response shows on the next
    wr_answer_a: assert property (wrTake |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("write not answered two cycles after it was taken");
    cmp_resp_a: assert property (wrTake && s_axi_awaddr == itm_pkg::CMP_ADDR |=> ##1 s_axi_bresp == itm_pkg::RESP_OKAY)
        else $error("compare write not answered okay");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed after response");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered one cycle after it was taken");
    r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed after data");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data wider than sixteen bits");
    err_data_a: assert property (s_axi_rvalid && s_axi_rresp != itm_pkg::RESP_OKAY |-> s_axi_rresp == itm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("error read carries data or odd code");
    irq_stop_a: assert property (!runSeen_ff [*6] |-> !compareMatchIrq)
        else $error("match pulse while stopped");
endmodule
bind itm_interval_timer itm_interval_timer_properties u_itm_interval_timer_properties (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .watchTickIrq, .internalOscClock, .subclock,
    .compareMatchIrq);
`default_nettype wire

// ==== itm_interval_timer_tb.sv ====
// self-checking bench of the interval timer: registers, count sources, periods
`timescale 1ns/1ps
`default_nettype none
module itm_interval_timer_tb;
    localparam int PW = 6;
    localparam logic [31:0] ST_BOTH = (32'h1 << itm_pkg::STAT_MATCH_BIT) |
                                      (32'h1 << itm_pkg::STAT_STARTED_BIT);
    logic        core_clk = 1'b0, arst_n = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, compareMatchIrq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        watchTickIrq = 1'b0, internalOscClock = 1'b0, subclock = 1'b0;
    logic [15:0] v, cmp;
    int          errors = 0, total_checks = 0, seed = 71, pinCnt = 0;
    int          tickLen[8] = '{1, 2, 4, 64, 512, PW, 32, 2 * PW};
    int          startMax[8] = '{2, 6, 24, 128, 1024, 2 * PW, 64, 4 * PW};

    itm_interval_timer u_itm_interval_timer (
        .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .watchTickIrq, .internalOscClock,
        .subclock, .compareMatchIrq);

    always #5 core_clk = ~core_clk;

    // distinct pin rates so a swapped source shows as a wrong period
    always @(posedge core_clk) begin
        pinCnt <= (pinCnt == 2 * PW - 1) ? 0 : pinCnt + 1;
        watchTickIrq <= (pinCnt % PW) < PW / 2;
        subclock <= pinCnt < PW;
        internalOscClock <= pinCnt[1];
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int exp_period(input logic [2:0] s, input logic [15:0] c);
        return (int'(c) + 1) * tickLen[s];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // bready stays high, so each write ends at its response edge; only the watchdog ends a hang
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task automatic wait_irq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (compareMatchIrq !== 1'b1 && n < lim);
    endtask

    // program while stopped, start, time first match and one period, stop
    task automatic run_case(input logic [2:0] sel, input logic [15:0] c);
        int t, per;
        per = exp_period(sel, c);
        axi_write(itm_pkg::CTRL_ADDR, {29'h0, sel}, 4'h1);
        axi_write(itm_pkg::CMP_ADDR, {16'h0, c}, 4'h3);
        axi_write(itm_pkg::CTRL_ADDR, {24'h0, 5'h10, sel}, 4'h1);
        wait_irq(startMax[sel] + per + 8, t);
        check("first match", 32'(t >= per && t < startMax[sel] + per + 8), 32'h1);
        wait_irq(per + 2, t);
        check("period", t, per);
        axi_read(itm_pkg::STAT_ADDR);
        check("status running", rd, ST_BOTH);
        axi_write(itm_pkg::CTRL_ADDR, {29'h0, sel}, 4'h1);
        repeat (6) @(posedge core_clk);
        wait_irq(2 * per + 40, t);
        check("stopped", t, 2 * per + 40);
        // match flag is write-one-to-clear, started falls with the run bit
        axi_write(itm_pkg::STAT_ADDR, ST_BOTH, 4'h1);
        axi_read(itm_pkg::STAT_ADDR);
        check("status stopped", rd, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        axi_read(itm_pkg::CTRL_ADDR);
        check("control reset", rd, {24'h0, itm_pkg::CTRL_RST});
        axi_read(itm_pkg::CMP_ADDR);
        check("compare reset", rd, {16'h0, itm_pkg::CMP_RST});
        axi_read(32'hfffff69c);
        check("unmapped", {30'h0, rs}, {30'h0, itm_pkg::RESP_SLVERR});
        for (int i = 0; i < 8; i++) begin
            v = 16'($random(seed));
            if (v == 16'hffff) v = 16'hfffe;
            axi_write(itm_pkg::CMP_ADDR, {16'h0, v}, 4'h3);
            axi_write(itm_pkg::CMP_ADDR, {16'h0, ~v}, 4'h1); // single byte lane must be dropped
            axi_read(itm_pkg::CMP_ADDR);
            check("compare", rd, {16'h0, v});
            axi_write(itm_pkg::CTRL_ADDR, {29'h0, v[2:0]}, 4'h1);
            axi_write(itm_pkg::CTRL_ADDR, 32'h7, 4'h0); // no byte lane, no effect
            axi_read(itm_pkg::CTRL_ADDR);
            check("control", rd, {29'h0, v[2:0]});
        end
        for (int s = 0; s < 8; s++) begin
            cmp = (s == 2) ? 16'h0 : 16'($random(seed) & 3);
            run_case(3'(s), cmp);
        end
        run_case(itm_pkg::CKS_MAIN, 16'h0);
        run_case(itm_pkg::CKS_DIV2, 16'h0009);
        close_out();
    end

    // hang guard, well past the longest expected run
    initial begin
        #500us;
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
